/* pkg/pnpms_consts.svh */
// Constants for the next page, indirect access and power-save register bank
`ifndef PNPMS_CONSTS_SVH
`define PNPMS_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define PNPMS_ADDR_W 5
`define PNPMS_DATA_W 16
`define PNPMS_IDX_NP_TX 5'h07
`define PNPMS_IDX_NP_RX 5'h08
`define PNPMS_IDX_IND_CTRL 5'h0d
`define PNPMS_IDX_IND_AD 5'h0e
`define PNPMS_IDX_PS_CFG 5'h10
`define PNPMS_IDX_MODE_CTRL 5'h11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PNPMS_NP_NEXT 15
`define PNPMS_NP_ACK 14
`define PNPMS_NP_MSG 13
`define PNPMS_NP_ACK2 12
`define PNPMS_NP_TOGGLE 11
`define PNPMS_NP_CODE_HI 10
`define PNPMS_NP_CODE_LO 0
`define PNPMS_IC_FUNC_HI 15
`define PNPMS_IC_FUNC_LO 14
`define PNPMS_IC_DEV_HI 4
`define PNPMS_IC_DEV_LO 0
`define PNPMS_PS_TXNLP 15
`define PNPMS_PS_TXINT_HI 14
`define PNPMS_PS_TXINT_LO 13
`define PNPMS_PS_RXONE 12
`define PNPMS_PS_RXINT_HI 11
`define PNPMS_PS_RXINT_LO 10
`define PNPMS_PS_EEE 2
`define PNPMS_PS_XSLEEP 1
`define PNPMS_PS_XMAN 0
`define PNPMS_MC_SLEEP_EN 13

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PNPMS_RST_NP_CODE 11'h001
`define PNPMS_RST_NP_MSG 1'b1
`define PNPMS_RST_XMAN 1'b1
`define PNPMS_RST_AD 16'h0000

// ----------------------------------------------------------------
// Indirect functions
// ----------------------------------------------------------------
`define PNPMS_FUNC_ADDR 2'h0
`define PNPMS_FUNC_DATA 2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PNPMS_CLK_HZ 10000000
`define PNPMS_MS_PER_S 1000
`define PNPMS_MS_CYCLES (`PNPMS_CLK_HZ / `PNPMS_MS_PER_S)
`define PNPMS_MS_W 12
`define PNPMS_T_1S_MS 12'd1000
`define PNPMS_T_768_MS 12'd768
`define PNPMS_T_512_MS 12'd512
`define PNPMS_T_256_MS 12'd256
`define PNPMS_T_64_MS 12'd64
`define PNPMS_T_LISTEN_MS 12'd256
`define PNPMS_XEXT_W 13
`define PNPMS_XEXT_SLEEP_MS 13'd2976
`define PNPMS_XEXT_MAN_MS 13'd1984
`define PNPMS_TICK_W 24

`endif

/* pkg/pnpms_pkg.sv */
// Types for the next page, indirect access and power-save register bank
package pnpms_pkg;

  typedef struct packed {
    logic next_page;
    logic ack;
    logic msg_page;
    logic ack2;
    logic toggle;
    logic [10:0] code;
  } pnpms_page_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pnpms_bus_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] dev;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pnpms_ind_req_t;

  // Gray order: awake -> asleep -> listening
  typedef enum logic [1:0] {
    PNPMS_AWAKE = 2'b00,
    PNPMS_ASLEEP = 2'b01,
    PNPMS_LISTEN = 2'b11
  } pnpms_state_t;

endpackage

/* design/pnpms_regs.sv */
// Next page, indirect device access and power-save register bank
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "pnpms_consts.svh"

// How it works
// - Transmit page bit 15 is writable next-page flag, reset 0.
// - Bit 13 marks message page; transmit writable reset 1, receive read-only reset 0.
// - Bit 12 is second acknowledge; transmit copy writable, reset 0.
// - Bit 11 is read-only toggle, reset 0, flips per page sent.
// - Bits 10:0 hold code; transmit resets to 001, receive to zero.
// - Receive register is read-only; bit 14 sets once a code word arrives.
// - Control bits 15:14 select address or data function, reset 00.
// - Control bits 4:0 select the target device, reset zero.
// - In address function, address/data writes latch the indirect register address.
// - Otherwise address/data accesses move data at the latched address; reset 0000h.
// - Asleep with bit 15 set, single link pulses are sent periodically.
// - Bits 14:13 pick pulse interval 1 s, 768, 512 or 256 ms.
// - Asleep with bit 12 set, one received pulse wakes the device.
// - Otherwise two pulses within 64, 256, 512 ms or 1 s wake it.
// - Bit 2 enables efficient ethernet operation, reset 0.
// - Asleep, bit 1 lengthens crossover time by 2976 ms.
// - Forced speed with auto crossover, bit 0 adds 1984 ms; reset 1.
// - Sleep mode is entered only while mode control bit 13 is set.
module pnpms_regs #(
  parameter int MS_CYCLES = `PNPMS_MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire pnpms_pkg::pnpms_bus_req_t bus_i,
  output logic [15:0] rdata_o,
  input wire logic rx_page_valid_i,
  input wire pnpms_pkg::pnpms_page_t rx_page_i,
  input wire logic tx_page_sent_i,
  output pnpms_pkg::pnpms_page_t tx_page_o,
  output pnpms_pkg::pnpms_ind_req_t ind_req_o,
  input wire logic [15:0] ind_rdata_i,
  input wire logic energy_i,
  input wire logic nlp_rx_i,
  input wire logic auto_mdix_i,
  input wire logic forced_speed_i,
  output logic nlp_tx_o,
  output logic energy_detect_sleep_mode_o,
  output logic efficient_ethernet_enable_o,
  output logic [12:0] xover_ext_ms_o
);
  import pnpms_pkg::*;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input pnpms_bus_req_t r, input logic [4:0] idx);
    hit = (r.addr == idx);
  endfunction

  function automatic logic [11:0] tx_interval(input logic [1:0] sel);
    case (sel)
      2'h0: tx_interval = `PNPMS_T_1S_MS;
      2'h1: tx_interval = `PNPMS_T_768_MS;
      2'h2: tx_interval = `PNPMS_T_512_MS;
      default: tx_interval = `PNPMS_T_256_MS;
    endcase
  endfunction

  function automatic logic [11:0] rx_interval(input logic [1:0] sel);
    case (sel)
      2'h0: rx_interval = `PNPMS_T_64_MS;
      2'h1: rx_interval = `PNPMS_T_256_MS;
      2'h2: rx_interval = `PNPMS_T_512_MS;
      default: rx_interval = `PNPMS_T_1S_MS;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  pnpms_page_t tx_q;
  pnpms_page_t rx_q;
  logic [1:0] func_q;
  logic [4:0] dev_q;
  logic [15:0] ind_addr_q;
  logic ps_txnlp_q;
  logic [1:0] ps_txint_q;
  logic ps_rxone_q;
  logic [1:0] ps_rxint_q;
  logic ps_eee_q;
  logic ps_xsleep_q;
  logic ps_xman_q;
  logic sleep_en_q;
  logic [15:0] rdata_q;
  pnpms_ind_req_t ind_q;

  logic wr_np_tx;
  logic wr_ctrl;
  logic wr_ad;
  logic rd_ad;
  logic wr_ps;
  logic wr_mc;
  logic data_mode;

  assign wr_np_tx = bus_i.wr && hit(bus_i, `PNPMS_IDX_NP_TX);
  assign wr_ctrl = bus_i.wr && hit(bus_i, `PNPMS_IDX_IND_CTRL);
  assign wr_ad = bus_i.wr && hit(bus_i, `PNPMS_IDX_IND_AD);
  assign rd_ad = bus_i.rd && hit(bus_i, `PNPMS_IDX_IND_AD);
  assign wr_ps = bus_i.wr && hit(bus_i, `PNPMS_IDX_PS_CFG);
  assign wr_mc = bus_i.wr && hit(bus_i, `PNPMS_IDX_MODE_CTRL);
  assign data_mode = (func_q != `PNPMS_FUNC_ADDR);

  // ----------------------------------------------------------------
  // Transmit next page
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_q.next_page <= 1'b0;
      tx_q.ack <= 1'b0;
      tx_q.msg_page <= `PNPMS_RST_NP_MSG;
      tx_q.ack2 <= 1'b0;
      tx_q.toggle <= 1'b0;
      tx_q.code <= `PNPMS_RST_NP_CODE;
    end else begin
      if (wr_np_tx) begin
        tx_q.next_page <= bus_i.wdata[`PNPMS_NP_NEXT];
        tx_q.msg_page <= bus_i.wdata[`PNPMS_NP_MSG];
        tx_q.ack2 <= bus_i.wdata[`PNPMS_NP_ACK2];
        tx_q.code <= bus_i.wdata[`PNPMS_NP_CODE_HI:`PNPMS_NP_CODE_LO];
      end
      if (tx_page_sent_i) begin
        tx_q.toggle <= ~tx_q.toggle;
      end
    end
  end

  assign tx_page_o = tx_q;

  // ----------------------------------------------------------------
  // Receive next page
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_q <= '0;
    end else if (rx_page_valid_i) begin
      rx_q <= rx_page_i;
      rx_q.ack <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Indirect access control and address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      func_q <= `PNPMS_FUNC_ADDR;
      dev_q <= '0;
    end else if (wr_ctrl) begin
      func_q <= bus_i.wdata[`PNPMS_IC_FUNC_HI:`PNPMS_IC_FUNC_LO];
      dev_q <= bus_i.wdata[`PNPMS_IC_DEV_HI:`PNPMS_IC_DEV_LO];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ind_addr_q <= `PNPMS_RST_AD;
    end else if (wr_ad && !data_mode) begin
      ind_addr_q <= bus_i.wdata;
    end
  end

  // Data function forwards each access at the latched address
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ind_q <= '0;
    end else begin
      ind_q.wr <= wr_ad && data_mode;
      ind_q.rd <= rd_ad && data_mode;
      if ((wr_ad || rd_ad) && data_mode) begin
        ind_q.dev <= dev_q;
        ind_q.addr <= ind_addr_q;
        ind_q.wdata <= bus_i.wdata;
      end
    end
  end

  assign ind_req_o = ind_q;

  // ----------------------------------------------------------------
  // Power-save and mode control configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ps_txnlp_q <= 1'b0;
      ps_txint_q <= '0;
      ps_rxone_q <= 1'b0;
      ps_rxint_q <= '0;
      ps_eee_q <= 1'b0;
      ps_xsleep_q <= 1'b0;
      ps_xman_q <= `PNPMS_RST_XMAN;
    end else if (wr_ps) begin
      ps_txnlp_q <= bus_i.wdata[`PNPMS_PS_TXNLP];
      ps_txint_q <= bus_i.wdata[`PNPMS_PS_TXINT_HI:`PNPMS_PS_TXINT_LO];
      ps_rxone_q <= bus_i.wdata[`PNPMS_PS_RXONE];
      ps_rxint_q <= bus_i.wdata[`PNPMS_PS_RXINT_HI:`PNPMS_PS_RXINT_LO];
      ps_eee_q <= bus_i.wdata[`PNPMS_PS_EEE];
      ps_xsleep_q <= bus_i.wdata[`PNPMS_PS_XSLEEP];
      ps_xman_q <= bus_i.wdata[`PNPMS_PS_XMAN];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_en_q <= 1'b0;
    end else if (wr_mc) begin
      sleep_en_q <= bus_i.wdata[`PNPMS_MC_SLEEP_EN];
    end
  end

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
    end else if (bus_i.rd) begin
      rdata_q <= '0;
      case (bus_i.addr)
        `PNPMS_IDX_NP_TX: begin
          rdata_q <= tx_q;
          rdata_q[`PNPMS_NP_ACK] <= 1'b0;
        end
        `PNPMS_IDX_NP_RX: rdata_q <= rx_q;
        `PNPMS_IDX_IND_CTRL: begin
          rdata_q[`PNPMS_IC_FUNC_HI:`PNPMS_IC_FUNC_LO] <= func_q;
          rdata_q[`PNPMS_IC_DEV_HI:`PNPMS_IC_DEV_LO] <= dev_q;
        end
        `PNPMS_IDX_IND_AD: rdata_q <= data_mode ? ind_rdata_i : ind_addr_q;
        `PNPMS_IDX_PS_CFG: begin
          rdata_q[`PNPMS_PS_TXNLP] <= ps_txnlp_q;
          rdata_q[`PNPMS_PS_TXINT_HI:`PNPMS_PS_TXINT_LO] <= ps_txint_q;
          rdata_q[`PNPMS_PS_RXONE] <= ps_rxone_q;
          rdata_q[`PNPMS_PS_RXINT_HI:`PNPMS_PS_RXINT_LO] <= ps_rxint_q;
          rdata_q[`PNPMS_PS_EEE] <= ps_eee_q;
          rdata_q[`PNPMS_PS_XSLEEP] <= ps_xsleep_q;
          rdata_q[`PNPMS_PS_XMAN] <= ps_xman_q;
        end
        `PNPMS_IDX_MODE_CTRL: rdata_q[`PNPMS_MC_SLEEP_EN] <= sleep_en_q;
        default: rdata_q <= '0;
      endcase
    end
  end

  assign rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // Pin synchronisers and pulse edge
  // ----------------------------------------------------------------
  logic [1:0] energy_sync_q;
  logic [2:0] nlp_sync_q;
  logic energy_s;
  logic nlp_rx_pulse;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      energy_sync_q <= '0;
      nlp_sync_q <= '0;
    end else begin
      energy_sync_q <= {energy_sync_q[0], energy_i};
      nlp_sync_q <= {nlp_sync_q[1:0], nlp_rx_i};
    end
  end

  assign energy_s = energy_sync_q[1];
  assign nlp_rx_pulse = nlp_sync_q[1] && !nlp_sync_q[2];

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [`PNPMS_TICK_W-1:0] tick_cnt_q;
  logic ms_tick;

  assign ms_tick = (tick_cnt_q == `PNPMS_TICK_W'(MS_CYCLES - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_q <= '0;
    end else if (ms_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + `PNPMS_TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------
  pnpms_state_t state_q;
  logic [`PNPMS_MS_W-1:0] tx_ms_q;
  logic [`PNPMS_MS_W-1:0] rx_ms_q;
  logic [`PNPMS_MS_W-1:0] listen_ms_q;
  logic rx_pending_q;
  logic wake;
  logic rx_expired;

  assign rx_expired = rx_ms_q >= rx_interval(ps_rxint_q);
  assign wake = nlp_rx_pulse && (ps_rxone_q || (rx_pending_q && !rx_expired));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= PNPMS_AWAKE;
    end else begin
      case (state_q)
        PNPMS_AWAKE: begin
          if (sleep_en_q && !energy_s) begin
            state_q <= PNPMS_ASLEEP;
          end
        end
        PNPMS_ASLEEP: begin
          if (!sleep_en_q || energy_s) begin
            state_q <= PNPMS_AWAKE;
          end else if (wake) begin
            state_q <= PNPMS_LISTEN;
          end
        end
        PNPMS_LISTEN: begin
          if (!sleep_en_q || energy_s) begin
            state_q <= PNPMS_AWAKE;
          end else if (ms_tick && listen_ms_q == `PNPMS_T_LISTEN_MS - 12'd1) begin
            state_q <= PNPMS_ASLEEP;
          end
        end
        default: state_q <= PNPMS_AWAKE;
      endcase
    end
  end

  // Listen window after a wake
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      listen_ms_q <= '0;
    end else if (state_q != PNPMS_LISTEN) begin
      listen_ms_q <= '0;
    end else if (ms_tick) begin
      listen_ms_q <= listen_ms_q + 12'd1;
    end
  end

  // Two-pulse wake window
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_pending_q <= 1'b0;
      rx_ms_q <= '0;
    end else if (state_q != PNPMS_ASLEEP || ps_rxone_q) begin
      rx_pending_q <= 1'b0;
      rx_ms_q <= '0;
    end else if (nlp_rx_pulse) begin
      rx_pending_q <= 1'b1;
      rx_ms_q <= '0;
    end else if (rx_pending_q && rx_expired) begin
      rx_pending_q <= 1'b0;
    end else if (ms_tick && rx_pending_q) begin
      rx_ms_q <= rx_ms_q + 12'd1;
    end
  end

  // Periodic single pulse while asleep
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_ms_q <= '0;
      nlp_tx_o <= 1'b0;
    end else begin
      nlp_tx_o <= 1'b0;
      if (state_q != PNPMS_ASLEEP || !ps_txnlp_q) begin
        tx_ms_q <= '0;
      end else if (ms_tick) begin
        if (tx_ms_q >= tx_interval(ps_txint_q) - 12'd1) begin
          tx_ms_q <= '0;
          nlp_tx_o <= 1'b1;
        end else begin
          tx_ms_q <= tx_ms_q + 12'd1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status outputs and crossover extension
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      energy_detect_sleep_mode_o <= 1'b0;
      efficient_ethernet_enable_o <= 1'b0;
      xover_ext_ms_o <= '0;
    end else begin
      energy_detect_sleep_mode_o <= (state_q != PNPMS_AWAKE);
      efficient_ethernet_enable_o <= ps_eee_q;
      xover_ext_ms_o <= ((ps_xsleep_q && state_q != PNPMS_AWAKE) ?
                         `PNPMS_XEXT_SLEEP_MS : 13'h0000) +
                        ((ps_xman_q && auto_mdix_i && forced_speed_i) ?
                         `PNPMS_XEXT_MAN_MS : 13'h0000);
    end
  end

endmodule
`default_nettype wire

/* tb/pnpms_regs_asserts.sv */
// Port-level checker for the next page, indirect access and power-save bank
`timescale 1ns/100ps
`default_nettype none
`include "pnpms_consts.svh"
module pnpms_regs_asserts (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire pnpms_pkg::pnpms_bus_req_t bus_i,
  input wire logic [15:0] rdata_o,
  input wire logic tx_page_sent_i,
  input wire pnpms_pkg::pnpms_page_t tx_page_o,
  input wire pnpms_pkg::pnpms_ind_req_t ind_req_o,
  input wire logic [15:0] ind_rdata_i,
  input wire logic nlp_tx_o,
  input wire logic energy_detect_sleep_mode_o,
  input wire logic efficient_ethernet_enable_o,
  input wire logic [12:0] xover_ext_ms_o
);
  import pnpms_pkg::*;
  // ----------------------------------------------------------------
  // Shadow copies of the written registers
  // ----------------------------------------------------------------
  logic [15:0] ctl_q;
  logic [15:0] adr_q;
  logic [15:0] ps_q;
  logic mc_q;
  logic ad_hit;
  logic fn_data;
  assign ad_hit = bus_i.addr == `PNPMS_IDX_IND_AD;
  assign fn_data = ctl_q[15:14] != `PNPMS_FUNC_ADDR;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctl_q <= 16'h0000;
      adr_q <= 16'h0000;
      ps_q <= 16'h0001;
      mc_q <= 1'b0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `PNPMS_IDX_IND_CTRL) ctl_q <= bus_i.wdata;
      if (ad_hit && !fn_data) adr_q <= bus_i.wdata;
      if (bus_i.addr == `PNPMS_IDX_PS_CFG) ps_q <= bus_i.wdata;
      if (bus_i.addr == `PNPMS_IDX_MODE_CTRL) mc_q <= bus_i.wdata[13];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence ad_wr_s; bus_i.wr && ad_hit && fn_data; endsequence
  sequence ad_rd_s; bus_i.rd && ad_hit && fn_data; endsequence
  ind_write_fwd_a: assert property (ad_wr_s |=> ind_req_o.wr && !ind_req_o.rd &&
    ind_req_o.wdata == $past(bus_i.wdata) && ind_req_o.addr == adr_q &&
    ind_req_o.dev == ctl_q[4:0]) else $error("indirect write not forwarded");
  ind_read_fwd_a: assert property (ad_rd_s |=> ind_req_o.rd &&
    rdata_o == $past(ind_rdata_i)) else $error("indirect read not forwarded");
  addr_mode_a: assert property ((bus_i.wr || bus_i.rd) && ad_hit && !fn_data |=>
    !ind_req_o.wr && !ind_req_o.rd) else $error("indirect request in address mode");
  addr_read_a: assert property (bus_i.rd && ad_hit && !fn_data |=>
    rdata_o == adr_q) else $error("latched address not read back");
  tx_page_wr_a: assert property (bus_i.wr && bus_i.addr == `PNPMS_IDX_NP_TX |=>
    (tx_page_o & 16'hf7ff) == ($past(bus_i.wdata) & 16'hb7ff)) else $error("tx page write");
  toggle_flip_a: assert property (tx_page_o.toggle ==
    ($past(tx_page_o.toggle) ^ $past(tx_page_sent_i))) else $error("toggle bit wrong");
  eee_follow_a: assert property ($changed(efficient_ethernet_enable_o) |->
    efficient_ethernet_enable_o == $past(ps_q[2])) else $error("eee enable mismatch");
  sleep_entry_a: assert property ($rose(energy_detect_sleep_mode_o) |-> $past(mc_q))
    else $error("sleep entered while disabled");
  nlp_asleep_a: assert property (nlp_tx_o |-> energy_detect_sleep_mode_o && $past(ps_q[15])
    ##1 !nlp_tx_o) else $error("link pulse outside sleep");
  xover_vals_a: assert property (xover_ext_ms_o inside {13'd0, `PNPMS_XEXT_MAN_MS,
    `PNPMS_XEXT_SLEEP_MS, 13'd4960}) else $error("crossover extension value");
endmodule
bind pnpms_regs pnpms_regs_asserts u_chk (.clk_i, .nrst_i, .bus_i, .rdata_o, .tx_page_sent_i,
  .tx_page_o, .ind_req_o, .ind_rdata_i, .nlp_tx_o, .energy_detect_sleep_mode_o,
  .efficient_ethernet_enable_o, .xover_ext_ms_o);
`default_nettype wire

/* tb/pnpms_host.sv */
// Station management master model for the register port
`timescale 1ns/100ps
`default_nettype none
module pnpms_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output pnpms_pkg::pnpms_bus_req_t bus_o
);
  import pnpms_pkg::*;
  initial bus_o = '0;
  // One-cycle write strobe with address and data
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    bus_o <= '0;
  endtask
  // Read data appears in the cycle after the strobe and holds until the next read
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk_i);
    bus_o <= '0;
    #1;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* tb/pnpms_regs_tb.sv */
// Self-checking bench for the next page, indirect access and power-save bank
`timescale 1ns/100ps
`default_nettype none
`include "pnpms_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module pnpms_regs_tb;
  import pnpms_pkg::*;
  localparam int MSC = 4;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  pnpms_bus_req_t bus;
  pnpms_page_t rx_pg, tx_pg;
  pnpms_ind_req_t ind;
  logic [15:0] rdata, ind_rdata, rv, d, ad, rxv;
  logic [4:0] a, dv;
  logic rx_vld, tx_sent, energy, nlp_rx, mdix, fspd, nlp_tx, slp, eee, tgl;
  logic [12:0] xov;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  logic [4:0] tab [6] = '{5'h07, 5'h08, 5'h0d, 5'h10, 5'h11, 5'h1f};
  logic [15:0] rst_v [6] = '{16'h2001, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
  int tx_ms [4] = '{1000, 768, 512, 256};
  always #50 clk_i = ~clk_i;
  pnpms_host host (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus));
  pnpms_regs #(.MS_CYCLES(MSC)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus),
    .rdata_o(rdata), .rx_page_valid_i(rx_vld), .rx_page_i(rx_pg), .tx_page_sent_i(tx_sent),
    .tx_page_o(tx_pg), .ind_req_o(ind), .ind_rdata_i(ind_rdata), .energy_i(energy),
    .nlp_rx_i(nlp_rx), .auto_mdix_i(mdix), .forced_speed_i(fspd), .nlp_tx_o(nlp_tx),
    .energy_detect_sleep_mode_o(slp), .efficient_ethernet_enable_o(eee),
    .xover_ext_ms_o(xov));
  function automatic logic [15:0] exp_rd(input logic [4:0] ra, input logic [15:0] wd);
    case (ra)
      `PNPMS_IDX_NP_TX: return (wd & 16'hb7ff) | {4'h0, tgl, 11'h000};
      `PNPMS_IDX_NP_RX: return rxv;
      `PNPMS_IDX_IND_CTRL: return wd & 16'hc01f;
      `PNPMS_IDX_PS_CFG: return wd & 16'hfc07;
      `PNPMS_IDX_MODE_CTRL: return wd & 16'h2000;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk_rd(input logic [4:0] ra, input logic [15:0] e);
    host.rd(ra, rv);
    `CHK("read data", e, rv)
  endtask
  // Cycles until the next transmitted link pulse
  task automatic wait_nlp(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      #1;
      c++;
    end while (nlp_tx !== 1'b1 && c < 4500);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    {rx_vld, tx_sent, energy, nlp_rx, mdix, fspd, tgl} = '0;
    rx_pg = '0;
    ind_rdata = '0;
    rxv = '0;
    n = $urandom(32'he994);
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    // ----------------------------------------------------------------
    // Reset values, random writes, read-only and unmapped places
    // ----------------------------------------------------------------
    foreach (tab[i]) chk_rd(tab[i], rst_v[i]);
    chk_rd(`PNPMS_IDX_IND_AD, 16'h0000);
    `CHK("sleep mode", 1'b0, slp)
    $display("test reset done");
    for (int i = 0; i < 18; i++) begin
      a = tab[i % 6];
      d = (i < 6) ? 16'hffff : 16'($urandom);
      host.wr(a, d);
      chk_rd(a, exp_rd(a, d));
    end
    host.wr(`PNPMS_IDX_MODE_CTRL, 16'h0000);
    $display("test readback done");
    // ----------------------------------------------------------------
    // Toggle and received page
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i) tx_sent <= 1'b1;
      @(posedge clk_i) tx_sent <= 1'b0;
      tgl = ~tgl;
      host.rd(`PNPMS_IDX_NP_TX, rv);
      `CHK("toggle bit", tgl, rv[11])
    end
    d = 16'($urandom) & 16'hbfff;
    @(posedge clk_i);
    rx_pg <= d;
    rx_vld <= 1'b1;
    @(posedge clk_i) rx_vld <= 1'b0;
    rxv = d | 16'h4000;
    chk_rd(`PNPMS_IDX_NP_RX, rxv);
    host.wr(`PNPMS_IDX_NP_RX, ~rxv);
    chk_rd(`PNPMS_IDX_NP_RX, rxv);
    $display("test pages done");
    // ----------------------------------------------------------------
    // Indirect access, all data function codes
    // ----------------------------------------------------------------
    for (int f = 1; f < 4; f++) begin
      dv = (f == 2) ? 5'h07 : 5'h03;
      ad = 16'($urandom);
      d = 16'($urandom);
      host.wr(`PNPMS_IDX_IND_CTRL, {2'h0, 9'h000, dv});
      host.wr(`PNPMS_IDX_IND_AD, ad);
      #1;
      `CHK("no indirect request", 2'b00, {ind.wr, ind.rd})
      chk_rd(`PNPMS_IDX_IND_AD, ad);
      host.wr(`PNPMS_IDX_IND_CTRL, {2'(f), 9'h000, dv});
      host.wr(`PNPMS_IDX_IND_AD, d);
      #1;
      `CHK("indirect write", {2'b10, dv, ad, d}, ind)
      ind_rdata = 16'($urandom);
      host.rd(`PNPMS_IDX_IND_AD, rv);
      `CHK("indirect read", ind_rdata, rv)
      `CHK("indirect read request", 1'b1, ind.rd)
    end
    $display("test indirect done");
    // ----------------------------------------------------------------
    // Power-down, link pulse intervals, crossover extension
    // ----------------------------------------------------------------
    @(posedge clk_i);
    mdix <= 1'b1;
    fspd <= 1'b1;
    host.wr(`PNPMS_IDX_PS_CFG, 16'he007);
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("eee enable", 1'b1, eee)
    `CHK("crossover awake", `PNPMS_XEXT_MAN_MS, xov)
    host.wr(`PNPMS_IDX_MODE_CTRL, 16'h2000);
    n = 0;
    while (slp !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("sleep mode", 1'b1, slp)
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("crossover asleep", 13'd4960, xov)
    for (int c = 0; c < 4; c++) begin
      host.wr(`PNPMS_IDX_PS_CFG, {1'b1, 2'(c), 1'b0, 2'(c), 7'h00, 3'b111});
      wait_nlp(n);
      wait_nlp(n);
      `CHK("pulse interval", tx_ms[c] * MSC, n)
    end
    // Wake on one pulse, then on two close pulses; a wake delays the next sent pulse
    for (int w = 0; w < 2; w++) begin
      host.wr(`PNPMS_IDX_PS_CFG, (w == 0) ? 16'hf007 : 16'he007);
      wait_nlp(n);
      repeat (w + 1) begin
        @(posedge clk_i) nlp_rx <= 1'b1;
        repeat (4) @(posedge clk_i) nlp_rx <= 1'b0;
      end
      wait_nlp(n);
      `CHK("pulse wake", 1'b1, n > tx_ms[3] * MSC)
    end
    @(posedge clk_i) energy <= 1'b1;
    n = 0;
    while (slp !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("sleep exit", 1'b0, slp)
    @(posedge clk_i) mdix <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("crossover off", 13'd0, xov)
    $display("test power done");
    @(posedge clk_i) nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk_rd(`PNPMS_IDX_PS_CFG, 16'h0001);
    $display("test second reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
